// ==== hdl/vector_crypto_group_legality.sv ====
// Legality checker and element group setup for vector crypto instructions
`timescale 1ns/10ps
module vector_crypto_group_legality
  import vcrypto_pkg::*;
#(
  parameter int unsigned VLEN = VLEN_DEFAULT,
  // Clear for the narrow hash variant, which reserves SEW 64 on the SHA-2 ops
  parameter bit SHA2_WIDE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire crypto_op_t req_op,
  input wire logic [4:0] vd,
  input wire logic [4:0] vs1,
  input wire logic [4:0] vs2,
  input wire logic [2:0] vsew,
  input wire logic [2:0] vlmul,
  input wire logic [15:0] vl,
  input wire logic [15:0] vstart,
  input wire logic vm,
  input wire logic vta,
  input wire logic vma,
  output logic rsp_valid,
  output logic illegal_instr,
  output logic [15:0] group_count,
  output logic [15:0] group_start,
  output logic [3:0] group_size_elements,
  output logic [8:0] group_width_bits,
  output logic [6:0] effective_element_width,
  output logic [3:0] scalar_regs,
  output logic [4:0] sub_opcode,
  output logic scalar_form,
  output logic tail_agnostic,
  output logic mask_agnostic,
  output logic masked
);
  // A scalar group is 128 bits, so narrow registers are ganged to hold it
  localparam logic [3:0] SCALAR_REGS_C =
    (VLEN >= 128) ? 4'h1 : (VLEN == 64) ? 4'h2 : 4'h4;
  localparam logic [1:0] LAT_LAST = 2'(LATENCY_CYCLES - 1);

  check_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic ill_q, ill_d;
  logic [15:0] gcount_q, gcount_d;
  logic [15:0] gstart_q, gstart_d;
  logic [3:0] gsize_q, gsize_d;
  logic [8:0] gwidth_q, gwidth_d;
  logic [6:0] eew_q, eew_d;
  logic [3:0] sregs_q, sregs_d;
  logic [4:0] subop_q, subop_d;
  logic sform_q, sform_d;
  logic ta_q, ta_d;
  logic ma_q, ma_d;
  logic msk_q, msk_d;
  logic valid_q, valid_d;

  // Decode combinational signals
  logic [3:0] size_c;
  logic [8:0] width_c;
  logic [6:0] sew_bits;
  logic sew_ok;
  logic uses_groups;
  logic is_scalar;
  logic chk_vs1;
  logic chk_vs2;
  logic [3:0] dst_regs;
  logic [19:0] lmul_vlen;
  logic lmul_bad;
  logic align_bad;
  logic ov_vs1;
  logic ov_vs2;
  logic [3:0] src2_regs;
  logic [3:0] lmul_regs;

  always_comb begin
    sew_bits = (vsew == VSEW_64) ? SEW_64 : (vsew == VSEW_32) ? SEW_32 : 7'h00;
    size_c = SIZE_4;
    width_c = WIDTH_128;
    sew_ok = (vsew == VSEW_32);
    uses_groups = 1'b1;
    is_scalar = 1'b0;
    chk_vs1 = 1'b0;
    chk_vs2 = 1'b0;
    case (req_op)
      op_aes_vv, op_ghash, op_sm4_key, op_sm4_round_vv: begin
      end
      op_aes_vs: begin
        is_scalar = 1'b1;
        chk_vs2 = 1'b1;
      end
      op_sm4_round_vs: begin
        is_scalar = 1'b1;
        chk_vs2 = 1'b1;
      end
      op_sha2_compress, op_sha2_msg_sched: begin
        chk_vs1 = 1'b1;
        chk_vs2 = 1'b1;
        if (vsew == VSEW_64) begin
          width_c = WIDTH_256;
        end
        sew_ok = (vsew == VSEW_32) || (SHA2_WIDE && (vsew == VSEW_64));
      end
      op_sm3_expand, op_sm3_compress: begin
        size_c = SIZE_8;
        width_c = WIDTH_256;
        chk_vs2 = 1'b1;
      end
      op_clmul: begin
        uses_groups = 1'b0;
        sew_ok = (vsew == VSEW_64);
      end
      default: begin
        uses_groups = 1'b0;
        sew_ok = 1'b0;
      end
    endcase
  end

  // LMUL*VLEN; fractional LMUL codes shift right
  always_comb begin
    lmul_vlen = 20'(VLEN);
    lmul_regs = 4'h1;
    case (vlmul)
      3'h0: lmul_regs = 4'h1;
      3'h1: lmul_regs = 4'h2;
      3'h2: lmul_regs = 4'h4;
      3'h3: lmul_regs = 4'h8;
      default: lmul_regs = 4'h1;
    endcase
    case (vlmul)
      3'h0, 3'h1, 3'h2, 3'h3: lmul_vlen = 20'(VLEN) << vlmul;
      3'h5: lmul_vlen = 20'(VLEN) >> 3;
      3'h6: lmul_vlen = 20'(VLEN) >> 2;
      3'h7: lmul_vlen = 20'(VLEN) >> 1;
      default: lmul_vlen = 20'h0_0000;
    endcase
    // Reserved vlmul code never gives a legal group
    lmul_bad = uses_groups && (lmul_vlen < {11'h000, width_c});
    // Group size is a power of two, so a low-bit mask tests the multiple
    align_bad = uses_groups &&
                (((vl & 16'({12'h000, size_c} - 16'h0001)) != 16'h0000) ||
                 ((vstart & 16'({12'h000, size_c} - 16'h0001)) != 16'h0000));
    dst_regs = lmul_regs;
    src2_regs = is_scalar ? SCALAR_REGS_C : lmul_regs;
  end

  reg_overlap u_ov_vs2 (
    .a_base(vd),
    .a_count(dst_regs),
    .b_base(vs2),
    .b_count(src2_regs),
    .hit(ov_vs2)
  );

  reg_overlap u_ov_vs1 (
    .a_base(vd),
    .a_count(dst_regs),
    .b_base(vs1),
    .b_count(lmul_regs),
    .hit(ov_vs1)
  );

  // Every reserved case except vlmul code 4 on op_clmul is folded into one illegal flag: no other undefined result
  // ever escapes, at the cost of giving software no finer cause code
  logic overlap_bad;
  logic sew_bad;
  logic reserved_c;
  logic illegal_c;

  always_comb begin
    overlap_bad = (chk_vs2 && ov_vs2) || (chk_vs1 && ov_vs1);
    sew_bad = !sew_ok;
    reserved_c = align_bad || sew_bad || overlap_bad;
    illegal_c = lmul_bad || reserved_c;
  end

  // Fixed latency: every request spends LATENCY_CYCLES in st_busy and one cycle in st_done, whatever its operands
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ill_d = ill_q;
    gcount_d = gcount_q;
    gstart_d = gstart_q;
    gsize_d = gsize_q;
    gwidth_d = gwidth_q;
    eew_d = eew_q;
    sregs_d = sregs_q;
    subop_d = subop_q;
    sform_d = sform_q;
    ta_d = ta_q;
    ma_d = ma_q;
    msk_d = msk_q;
    valid_d = 1'b0;
    // A request seen while busy is dropped; the issuer must wait for rsp_valid
    case (state_q)
      st_idle: begin
        if (req_valid) begin
          ill_d = illegal_c;
          gsize_d = uses_groups ? size_c : 4'h1;
          gwidth_d = uses_groups ? width_c : {2'b00, sew_bits};
          eew_d = sew_bits;
          gcount_d = (size_c == SIZE_8) ? (vl >> 3) : (vl >> 2);
          gstart_d = (size_c == SIZE_8) ? (vstart >> 3) : (vstart >> 2);
          if (!uses_groups) begin
            gcount_d = vl;
            gstart_d = vstart;
          end
          sregs_d = is_scalar ? SCALAR_REGS_C : 4'h0;
          subop_d = is_scalar ? vs1 : 5'h00;
          sform_d = is_scalar;
          ta_d = vta;
          ma_d = vma;
          msk_d = !vm;
          cnt_d = 2'b00;
          state_d = st_busy;
        end
      end
      st_busy: begin
        if (cnt_q == LAT_LAST) begin
          state_d = st_done;
        end else begin
          cnt_d = cnt_q + 2'b01;
        end
      end
      st_done: begin
        valid_d = 1'b1;
        state_d = st_idle;
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      cnt_q <= 2'b00;
      ill_q <= 1'b0;
      gcount_q <= 16'h0000;
      gstart_q <= 16'h0000;
      gsize_q <= 4'h0;
      gwidth_q <= 9'h000;
      eew_q <= 7'h00;
      sregs_q <= 4'h0;
      subop_q <= 5'h00;
      sform_q <= 1'b0;
      ta_q <= 1'b0;
      ma_q <= 1'b0;
      msk_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ill_q <= ill_d;
      gcount_q <= gcount_d;
      gstart_q <= gstart_d;
      gsize_q <= gsize_d;
      gwidth_q <= gwidth_d;
      eew_q <= eew_d;
      sregs_q <= sregs_d;
      subop_q <= subop_d;
      sform_q <= sform_d;
      ta_q <= ta_d;
      ma_q <= ma_d;
      msk_q <= msk_d;
      valid_q <= valid_d;
    end
  end

  // Element order within a group is the datapath's: index 0 is the rightmost
  // Result fields stand until the next accepted request
  assign rsp_valid = valid_q;
  assign illegal_instr = ill_q;
  assign group_count = gcount_q;
  assign group_start = gstart_q;
  assign group_size_elements = gsize_q;
  assign group_width_bits = gwidth_q;
  assign effective_element_width = eew_q;
  assign scalar_regs = sregs_q;
  assign sub_opcode = subop_q;
  assign scalar_form = sform_q;
  assign tail_agnostic = ta_q;
  assign mask_agnostic = ma_q;
  assign masked = msk_q;
endmodule

// ==== pkg/vcrypto_pkg.sv ====
// Package: constants and types for vector crypto group legality checks
package vcrypto_pkg;
  localparam int unsigned VLEN_DEFAULT = 128;
  localparam logic [8:0] WIDTH_128 = 9'h080;
  localparam logic [8:0] WIDTH_256 = 9'h100;
  localparam logic [3:0] SIZE_4 = 4'h4;
  localparam logic [3:0] SIZE_8 = 4'h8;
  localparam logic [6:0] SEW_32 = 7'h20;
  localparam logic [6:0] SEW_64 = 7'h40;
  localparam logic [7:0] SCALAR_GROUP_BITS = 8'h80;
  localparam int unsigned LATENCY_CYCLES = 2;
  // Vector SEW encoding (vsew field)
  localparam logic [2:0] VSEW_32 = 3'h2;
  localparam logic [2:0] VSEW_64 = 3'h3;

  typedef enum logic [3:0] {
    op_aes_vv,
    op_aes_vs,
    op_sha2_compress,
    op_sha2_msg_sched,
    op_ghash,
    op_sm4_key,
    op_sm4_round_vv,
    op_sm4_round_vs,
    op_sm3_expand,
    op_sm3_compress,
    op_clmul,
    op_none
  } crypto_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_busy,
    st_done
  } check_state_t;
endpackage

// ==== hdl/reg_overlap.sv ====
// Overlap test between two vector register groups
`timescale 1ns/10ps
module reg_overlap (
  input wire logic [4:0] a_base,
  input wire logic [3:0] a_count,
  input wire logic [4:0] b_base,
  input wire logic [3:0] b_count,
  output logic hit
);
  logic [5:0] a_end;
  logic [5:0] b_end;
  always_comb begin
    a_end = {1'b0, a_base} + {2'b00, a_count};
    b_end = {1'b0, b_base} + {2'b00, b_count};
    hit = ({1'b0, a_base} < b_end) && ({1'b0, b_base} < a_end);
  end
endmodule

// ==== tb/core_issuer.sv ====
// Model of the decoder side that hands requests to the block
`timescale 1ns/10ps
module core_issuer (
  input wire logic clk,
  output logic req_valid
);
  initial req_valid = 1'b0;
  // High for one rising edge only, so a held request is never taken twice
  task automatic issue;
    @(negedge clk);
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
endmodule

// ==== tb/vector_crypto_group_legality_assertions.sv ====
// Port-level checks of the legality block
`timescale 1ns/10ps
module vector_crypto_group_legality_assertions
  import vcrypto_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire crypto_op_t req_op,
  input wire logic [2:0] vsew,
  input wire logic [15:0] vl,
  input wire logic [15:0] vstart,
  input wire logic vm,
  input wire logic vta,
  input wire logic vma,
  input wire logic rsp_valid,
  input wire logic illegal_instr,
  input wire logic [15:0] group_count,
  input wire logic [15:0] group_start,
  input wire logic [6:0] effective_element_width,
  input wire logic tail_agnostic,
  input wire logic mask_agnostic,
  input wire logic masked
);
  logic busy_q;
  crypto_op_t op_q;
  logic [15:0] vl_q;
  logic [15:0] vst_q;
  logic [2:0] sew_q;
  logic [2:0] pol_q;
  logic take;
  logic [3:0] sz;
  logic fam32;
  assign take = req_valid && (!busy_q || rsp_valid);
  assign sz = (op_q inside {op_sm3_expand, op_sm3_compress}) ? SIZE_8 : SIZE_4;
  assign fam32 = op_q inside {op_aes_vv, op_aes_vs, op_ghash, op_sm3_expand, op_sm3_compress,
    op_sm4_key, op_sm4_round_vv, op_sm4_round_vs};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_q <= 1'b0;
    else if (take)
      busy_q <= 1'b1;
    else if (rsp_valid)
      busy_q <= 1'b0;
  end
  // Operands are latched at the take edge, since the decoder may move on
  always_ff @(posedge clk) begin
    if (take) begin
      op_q <= req_op;
      vl_q <= vl;
      vst_q <= vstart;
      sew_q <= vsew;
      pol_q <= {vta, vma, vm};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pulse_short: assert property (rsp_valid |=> !rsp_valid)
    else $error("rsp_valid held too long");
  a_resp_bound: assert property (take |-> ##[1:6] rsp_valid)
    else $error("no response in time");
  a_fixed_latency: assert property (take |-> ##1 !rsp_valid[*3] ##1 rsp_valid)
    else $error("response latency not fixed");
  a_group_count: assert property (rsp_valid && !illegal_instr && op_q != op_clmul
    |-> group_count == vl_q / sz)
    else $error("group count wrong");
  a_group_start: assert property (rsp_valid && !illegal_instr && op_q != op_clmul
    |-> group_start == vst_q / sz)
    else $error("group start wrong");
  a_align_check: assert property (rsp_valid && op_q != op_clmul
    && (vl_q % sz != 0 || vst_q % sz != 0) |-> illegal_instr)
    else $error("misaligned count accepted");
  a_eew_sel: assert property (rsp_valid && !illegal_instr |->
    effective_element_width == (sew_q == VSEW_64 ? SEW_64 : SEW_32))
    else $error("element width wrong");
  a_sew_fixed: assert property (rsp_valid && fam32 && sew_q != VSEW_32 |-> illegal_instr)
    else $error("wrong SEW accepted");
  a_policy_copy: assert property (rsp_valid |->
    {tail_agnostic, mask_agnostic, masked} == {pol_q[2], pol_q[1], !pol_q[0]})
    else $error("policy bits wrong");
  c_take: cover property (take);
  c_legal: cover property (rsp_valid && !illegal_instr);
  c_illegal: cover property (rsp_valid && illegal_instr);
endmodule
bind vector_crypto_group_legality vector_crypto_group_legality_assertions chk_i (
  .clk, .rst_n, .req_valid, .req_op, .vsew, .vl, .vstart, .vm, .vta, .vma,
  .rsp_valid, .illegal_instr, .group_count, .group_start, .effective_element_width,
  .tail_agnostic, .mask_agnostic, .masked);

// ==== tb/vector_crypto_group_legality_test.sv ====
// Self-checking bench for the legality block
`timescale 1ns/10ps
module vector_crypto_group_legality_test;
  import vcrypto_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid;
  logic vm = 1'b1;
  logic vta = 1'b0;
  logic vma = 1'b1;
  crypto_op_t req_op = op_aes_vv;
  logic [4:0] vd = 5'h00;
  logic [4:0] vs1 = 5'h00;
  logic [4:0] vs2 = 5'h00;
  logic [4:0] sub_opcode;
  logic [2:0] vsew = VSEW_32;
  logic [2:0] vlmul = 3'h0;
  logic [15:0] vl = 16'h0000;
  logic [15:0] vstart = 16'h0000;
  logic [15:0] group_count;
  logic [15:0] group_start;
  logic rsp_valid, illegal_instr, scalar_form, tail_agnostic, mask_agnostic, masked;
  logic [3:0] group_size_elements;
  logic [3:0] scalar_regs;
  logic [8:0] group_width_bits;
  logic [6:0] effective_element_width;
  int mismatches = 0;
  int n_compared = 0;
  core_issuer p (.clk, .req_valid);
  vector_crypto_group_legality dut (.clk, .rst_n, .req_valid, .req_op, .vd, .vs1, .vs2,
    .vsew, .vlmul, .vl, .vstart, .vm, .vta, .vma, .rsp_valid, .illegal_instr,
    .group_count, .group_start, .group_size_elements, .group_width_bits,
    .effective_element_width, .scalar_regs, .sub_opcode, .scalar_form,
    .tail_agnostic, .mask_agnostic, .masked);
  initial forever #50 clk = ~clk;
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task give_verdict;
    $display("Compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task run(input crypto_op_t o, input logic [2:0] s, input logic [2:0] m,
    input logic [15:0] n, input logic [15:0] st, input logic [4:0] d,
    input logic [4:0] a, input logic [4:0] b, input logic ill);
    int t;
    req_op = o;
    vsew = s;
    vlmul = m;
    vl = n;
    vstart = st;
    vd = d;
    vs1 = a;
    vs2 = b;
    p.issue();
    t = 1;
    while (rsp_valid !== 1'b1 && t < 20) begin
      @(negedge clk);
      t++;
    end
    if (t == 20) begin
      mismatches++;
      give_verdict();
    end
    chk("latency", 16'(LATENCY_CYCLES + 2), 16'(t));
    chk("illegal", 16'(ill), 16'(illegal_instr));
  endtask
  task t_groups;
    run(op_aes_vv, VSEW_32, 3'h0, 16'h0008, 16'h0004, 5'h08, 5'h00, 5'h10, 1'b0);
    chk("count", 16'h0002, group_count);
    chk("start", 16'h0001, group_start);
    chk("width", 16'h0080, 16'(group_width_bits));
    chk("eew", 16'h0020, 16'(effective_element_width));
    run(op_sm3_compress, VSEW_32, 3'h1, 16'h0010, 16'h0008, 5'h08, 5'h00, 5'h10, 1'b0);
    chk("size", 16'h0008, 16'(group_size_elements));
    chk("width", 16'h0100, 16'(group_width_bits));
    run(op_sha2_compress, VSEW_64, 3'h1, 16'h0004, 16'h0000, 5'h08, 5'h10, 5'h18, 1'b0);
    chk("eew", 16'h0040, 16'(effective_element_width));
    $display("Test groups done");
  endtask
  task t_reserved;
    run(op_ghash, VSEW_32, 3'h0, 16'h0006, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_sm3_expand, VSEW_32, 3'h1, 16'h000c, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_sm4_key, VSEW_32, 3'h0, 16'h0008, 16'h0002, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_sm3_compress, VSEW_32, 3'h0, 16'h0000, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_aes_vv, VSEW_64, 3'h0, 16'h0004, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_clmul, VSEW_32, 3'h0, 16'h0004, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_clmul, VSEW_64, 3'h0, 16'h0004, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b0);
    run(op_sha2_msg_sched, 3'h1, 3'h1, 16'h0004, 16'h0000, 5'h08, 5'h10, 5'h18, 1'b1);
    run(op_aes_vv, VSEW_32, 3'h7, 16'h0004, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_ghash, VSEW_32, 3'h4, 16'h0004, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    run(op_none, VSEW_32, 3'h0, 16'h0004, 16'h0000, 5'h08, 5'h00, 5'h10, 1'b1);
    $display("Test reserved done");
  endtask
  task t_overlap;
    run(op_aes_vs, VSEW_32, 3'h1, 16'h0008, 16'h0000, 5'h02, 5'h07, 5'h03, 1'b1);
    vta = 1'b1;
    vma = 1'b0;
    vm = 1'b0;
    run(op_aes_vs, VSEW_32, 3'h1, 16'h0008, 16'h0000, 5'h02, 5'h07, 5'h04, 1'b0);
    chk("subop", 16'h0007, 16'(sub_opcode));
    chk("sregs", 16'h0001, 16'(scalar_regs));
    chk("sform", 16'h0001, 16'(scalar_form));
    chk("policy", 16'h0005, 16'({tail_agnostic, mask_agnostic, masked}));
    run(op_sm4_round_vs, VSEW_32, 3'h0, 16'h0004, 16'h0000, 5'h04, 5'h00, 5'h04, 1'b1);
    run(op_sha2_compress, VSEW_32, 3'h1, 16'h0004, 16'h0000, 5'h08, 5'h09, 5'h10, 1'b1);
    run(op_sha2_msg_sched, VSEW_32, 3'h1, 16'h0004, 16'h0000, 5'h08, 5'h10, 5'h09, 1'b1);
    run(op_sm3_expand, VSEW_32, 3'h1, 16'h0008, 16'h0000, 5'h08, 5'h00, 5'h09, 1'b1);
    run(op_sm4_round_vv, VSEW_32, 3'h0, 16'h0004, 16'h0000, 5'h08, 5'h08, 5'h08, 1'b0);
    chk("sform", 16'h0000, 16'(scalar_form));
    chk("sregs", 16'h0000, 16'(scalar_regs));
    chk("subop", 16'h0000, 16'(sub_opcode));
    $display("Test overlap done");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_groups();
    t_reserved();
    t_overlap();
    give_verdict();
  end
endmodule
